// File: src/telemetry_regs.sv
// command register set: telemetry reads, revision and per-channel config
`include "telemetry_defines.svh"

module telemetry_regs #(
    parameter int CHANNELS = 8
) (
    input  wire logic                             CLK,
    input  wire logic                             RST_N,
    input  wire logic                             CMD_WR,
    input  wire logic                             CMD_RD,
    input  wire logic [7:0]                       CMD_CODE,
    input  wire logic [15:0]                      CMD_WDATA,
    output logic      [15:0]                      CMD_RDATA,
    output logic                                  CMD_RVALID,
    output logic                                  CMD_UNSUPPORTED,
    input  wire telemetry_pkg::sample_t           VIN_SAMPLE,
    input  wire telemetry_pkg::sample_t           TEMP_SAMPLE,
    input  wire telemetry_pkg::sample_t [CHANNELS-1:0] VOUT_SAMPLE,
    input  wire logic [CHANNELS-1:0]              VOUT_L11_IN,
    input  wire logic                             CONTROL_INPUT_ZERO,
    input  wire logic                             CONTROL_INPUT_ONE,
    input  wire logic [CHANNELS-1:0]              WARN_HIT,
    input  wire logic [CHANNELS-1:0]              TARGET_REACHED,
    output telemetry_pkg::chan_cfg_t [CHANNELS-1:0] CHAN_CFG,
    output logic [CHANNELS-1:0]                   CHAN_CONTROL,
    output logic [CHANNELS-1:0]                   FAST_SERVO_EN,
    output logic [CHANNELS-1:0]                   ADC_HIRES_EN,
    output logic [CHANNELS-1:0]                   SERVO_REQ,
    output logic [CHANNELS-1:0]                   DAC_CONNECT_NOW,
    output logic [CHANNELS-1:0]                   DAC_SOFT_CONNECT,
    output logic [CHANNELS-1:0]                   VOUT_IS_L11
);
    localparam int PW = (CHANNELS > 1) ? $clog2(CHANNELS) : 1;

    // ***********************************************
    // state
    // ***********************************************
    logic [15:0]          vin_r,  vin_nxt;
    logic [15:0]          temp_r, temp_nxt;
    logic [15:0]          vout_r   [CHANNELS];
    logic [15:0]          vout_nxt [CHANNELS];
    logic [15:0]          cfg_r    [CHANNELS];
    logic [15:0]          cfg_nxt  [CHANNELS];
    logic [PW-1:0]        page_r,  page_nxt;
    logic [15:0]          rdata_r, rdata_nxt;
    logic                 rvalid_r, rvalid_nxt;
    logic                 unsup_r, unsup_nxt;
    logic [CHANNELS-1:0]  l11_r, l11_nxt;

    // odd channels only may run hires
    function automatic logic hires_eff(input logic [15:0] cfg,
                                       input int ch);
        hires_eff = cfg[`BIT_ADC_HIRES] & ch[0];
    endfunction

    // ***********************************************
    // next state
    // ***********************************************
    always_comb
    begin
        // whole-word capture, so a read never sees a mixed word
        vin_nxt  = VIN_SAMPLE.valid ? VIN_SAMPLE.value
                                    : vin_r;
        temp_nxt = TEMP_SAMPLE.valid ? TEMP_SAMPLE.value
                                     : temp_r;
        page_nxt = page_r;
        for (int i = 0; i < CHANNELS; i++)
        begin
            vout_nxt[i] = VOUT_SAMPLE[i].valid ? VOUT_SAMPLE[i].value
                                               : vout_r[i];
            l11_nxt[i]  = VOUT_SAMPLE[i].valid ? VOUT_L11_IN[i] : l11_r[i];
            cfg_nxt[i]  = cfg_r[i];
        end
        if (CMD_WR)
        begin
            case (CMD_CODE)
                `CMD_PAGE:
                    page_nxt = CMD_WDATA[PW-1:0];
                `CMD_CHAN_CONFIG:
                    cfg_nxt[page_r] = CMD_WDATA & `CFG_WRITE_MASK;
                default:
                    page_nxt = page_r;
            endcase
        end
        rvalid_nxt = CMD_RD;
        rdata_nxt  = rdata_r;
        unsup_nxt  = 1'b0;
        if (CMD_RD)
        begin
            case (CMD_CODE)
                `CMD_READ_VIN:    rdata_nxt = vin_r;
                `CMD_READ_VOUT:   rdata_nxt = vout_r[page_r];
                `CMD_READ_TEMP:   rdata_nxt = temp_r;
                `CMD_REVISION:
                    rdata_nxt = {8'h00, `REVISION_VALUE};
                `CMD_CHAN_CONFIG:
                    rdata_nxt = cfg_r[page_r]
                              & `CFG_WRITE_MASK;
                `CMD_PAGE:        rdata_nxt = 16'(page_r);
                default:
                begin
                    rdata_nxt = 16'h0000;
                    unsup_nxt = 1'b1;
                end
            endcase
        end
        // writes to read-only commands are flagged as unsupported
        if (CMD_WR && CMD_CODE != `CMD_PAGE && CMD_CODE != `CMD_CHAN_CONFIG)
        begin
            unsup_nxt = 1'b1;
        end
    end

    // ***********************************************
    // registers
    // ***********************************************
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            vin_r    <= 16'h0000;
            temp_r   <= 16'h0000;
            page_r   <= '0;
            rdata_r  <= 16'h0000;
            rvalid_r <= 1'b0;
            unsup_r  <= 1'b0;
            l11_r    <= '0;
            for (int i = 0; i < CHANNELS; i++)
            begin
                vout_r[i] <= 16'h0000;
                cfg_r[i]  <= `CFG_RESET;
            end
        end
        else
        begin
            vin_r    <= vin_nxt;
            temp_r   <= temp_nxt;
            page_r   <= page_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            unsup_r  <= unsup_nxt;
            l11_r    <= l11_nxt;
            for (int i = 0; i < CHANNELS; i++)
            begin
                vout_r[i] <= vout_nxt[i];
                cfg_r[i]  <= cfg_nxt[i];
            end
        end
    end

    assign CMD_RDATA       = rdata_r;
    assign CMD_RVALID      = rvalid_r;
    assign CMD_UNSUPPORTED = unsup_r;

    // ***********************************************
    // per-channel decode of the configuration word
    // ***********************************************
    for (genvar g = 0; g < CHANNELS; g++)
    begin : g_chan
        telemetry_pkg::dac_mode_t mode;
        logic servo_mode;
        assign mode = telemetry_pkg::dac_mode_t'(
                      cfg_r[g][`DAC_MODE_HI:`DAC_MODE_LO]);
        assign servo_mode = (mode == telemetry_pkg::DAC_SERVO);

        assign CHAN_CFG[g].fast_servo_off = cfg_r[g][`BIT_FAST_SERVO];
        assign CHAN_CFG[g].sup_8mv        = cfg_r[g][`BIT_SUP_RES];
        assign CHAN_CFG[g].adc_hires      = hires_eff(cfg_r[g], g);
        assign CHAN_CFG[g].ctrl_sel       = cfg_r[g][`BIT_CTRL_SEL];
        assign CHAN_CFG[g].servo_cont     = cfg_r[g][`BIT_SERVO_CONT];
        assign CHAN_CFG[g].servo_on_warn  = cfg_r[g][`BIT_SERVO_WARN];
        assign CHAN_CFG[g].dac_mode       = mode;

        assign FAST_SERVO_EN[g] = ~cfg_r[g][`BIT_FAST_SERVO];
        assign ADC_HIRES_EN[g]  = hires_eff(cfg_r[g], g);
        assign CHAN_CONTROL[g]  = cfg_r[g][`BIT_CTRL_SEL]
                                ? CONTROL_INPUT_ONE
                                : CONTROL_INPUT_ZERO;
        // servo until target, or always when continuous, or on a warning
        assign SERVO_REQ[g] = servo_mode &&
            (!TARGET_REACHED[g]
             || cfg_r[g][`BIT_SERVO_CONT]
             || (cfg_r[g][`BIT_SERVO_WARN] && WARN_HIT[g]));
        // direct connect relies on the host having loaded the DAC code
        assign DAC_CONNECT_NOW[g]  =
            (mode == telemetry_pkg::DAC_DIRECT);
        assign DAC_SOFT_CONNECT[g] = servo_mode ||
            (mode == telemetry_pkg::DAC_SOFT);
        // engine tags each sample; hires odd channels report L11 mV
        assign VOUT_IS_L11[g] = l11_r[g];
    end
endmodule

// File: inc/telemetry_defines.svh
// constants for the telemetry and channel configuration command block
//
// Contract
// - input voltage read returns latest input sense result, L11 volts
// - output voltage read returns selected channel's latest result, L16 V
// - odd channel with hires bit set returns L11 millivolts instead
// - temperature read returns latest junction temperature, L11 Celsius
// - revision command is read only and returns 8'h11
// - every channel holds its own 16-bit configuration word
// - configuration bits 15:12 ignored on write, read back zero
// - bit 11 set disables fast servo during margin or trim
// - bit 10 selects supervisor resolution, 4mV or 8mV per step
// - bit 9 selects hires ADC on odd channels only
// - bit 8 selects control input zero or control input one
// - bit 7 continuous servo, applies only in DAC mode 00
// - bit 6 re-servo on warning, only mode 00 and not continuous
// - DAC mode 00 soft-connect and servo, 01 DAC disconnected
// - mode 10 connects at once with stored code, 11 soft-connects
`ifndef TELEMETRY_DEFINES_SVH
`define TELEMETRY_DEFINES_SVH

`define CMD_PAGE          8'h00
`define CMD_REVISION      8'h98
`define CMD_READ_VIN      8'h88
`define CMD_READ_VOUT     8'h8b
`define CMD_READ_TEMP     8'h8d
`define CMD_CHAN_CONFIG   8'hd0
`define REVISION_VALUE    8'h11
`define CFG_WRITE_MASK    16'h0fff
`define CFG_RESET         16'h0000
`define BIT_FAST_SERVO    11
`define BIT_SUP_RES       10
`define BIT_ADC_HIRES     9
`define BIT_CTRL_SEL      8
`define BIT_SERVO_CONT    7
`define BIT_SERVO_WARN    6
`define DAC_MODE_HI       5
`define DAC_MODE_LO       4

`endif

// File: inc/telemetry_pkg.sv
// types shared by the telemetry and configuration block
package telemetry_pkg;
    typedef enum logic [1:0]
    {
        DAC_SERVO   = 2'h0,
        DAC_OFF     = 2'h1,
        DAC_DIRECT  = 2'h2,
        DAC_SOFT    = 2'h3
    } dac_mode_t;

    typedef struct packed
    {
        logic        valid;
        logic [15:0] value;
    } sample_t;

    typedef struct packed
    {
        logic        fast_servo_off;
        logic        sup_8mv;
        logic        adc_hires;
        logic        ctrl_sel;
        logic        servo_cont;
        logic        servo_on_warn;
        dac_mode_t   dac_mode;
    } chan_cfg_t;
endpackage

// File: tb/telemetry_regs_asserts.sv
// concurrent checks on the command register block ports
// ****
// checker
// ****
module telemetry_regs_asserts #(
    parameter int CHANNELS = 8
) (
    input wire logic                            CLK,
    input wire logic                            RST_N,
    input wire logic                            CMD_WR,
    input wire logic                            CMD_RD,
    input wire logic [7:0]                      CMD_CODE,
    input wire logic [15:0]                     CMD_RDATA,
    input wire logic                            CMD_RVALID,
    input wire logic                            CMD_UNSUPPORTED,
    input wire logic                            CONTROL_INPUT_ZERO,
    input wire logic                            CONTROL_INPUT_ONE,
    input wire telemetry_pkg::chan_cfg_t [CHANNELS-1:0] CHAN_CFG,
    input wire logic [CHANNELS-1:0]             CHAN_CONTROL,
    input wire logic [CHANNELS-1:0]             FAST_SERVO_EN,
    input wire logic [CHANNELS-1:0]             ADC_HIRES_EN,
    input wire logic [CHANNELS-1:0]             SERVO_REQ,
    input wire logic [CHANNELS-1:0]             DAC_CONNECT_NOW,
    input wire logic [CHANNELS-1:0]             DAC_SOFT_CONNECT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_rd_answer: assert property (CMD_RD |=> CMD_RVALID)
        else $error("read not answered next cycle");
    a_rev_value: assert property (CMD_RD && CMD_CODE == 8'h98
        |=> CMD_RDATA == 16'h0011) else $error("revision word wrong");
    a_rev_locked: assert property (CMD_WR && CMD_CODE == 8'h98
        |=> CMD_UNSUPPORTED) else $error("revision write not refused");
    a_cfg_top: assert property (CMD_RD && CMD_CODE == 8'hd0
        |=> CMD_RDATA[15:12] == 4'h0) else $error("config top bits set");
    a_fast_servo: assert property (FAST_SERVO_EN[0]
        != CHAN_CFG[0].fast_servo_off) else $error("fast servo wrong");
    a_hires_odd: assert property (!ADC_HIRES_EN[0] &&
        ADC_HIRES_EN[1] == CHAN_CFG[1].adc_hires) else $error("hires wrong");
    a_ctrl_pick: assert property (CHAN_CONTROL[0] == (CHAN_CFG[0].ctrl_sel ?
        CONTROL_INPUT_ONE : CONTROL_INPUT_ZERO)) else $error("control pick");
    a_dac_direct: assert property (DAC_CONNECT_NOW[0] ==
        (CHAN_CFG[0].dac_mode == telemetry_pkg::DAC_DIRECT))
        else $error("dac connect wrong");
    a_servo_gate: assert property (CHAN_CFG[0].dac_mode[0]
        || CHAN_CFG[0].dac_mode[1] |-> !SERVO_REQ[0]) else $error("servo");
endmodule
bind telemetry_regs telemetry_regs_asserts #(.CHANNELS(CHANNELS)) chk (.*);

// File: tb/telemetry_engine_model.sv
// conversion engine stand-in feeding whole sample words
module telemetry_engine_model #(
    parameter int N = 4
) (
    input wire logic                        CLK,
    input wire logic [N-1:0]                trig,
    input wire logic [15:0]                 value,
    output telemetry_pkg::sample_t [N-1:0]  smp
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle words churn so a load off the valid pulse shows
    always_ff @(posedge CLK)
        for (int i = 0; i < N; i++)
        begin
            smp[i].valid <= trig[i];
            smp[i].value <= trig[i] ? value : ~smp[i].value;
        end
endmodule

// File: tb/telemetry_regs_tb_top.sv
// self-checking bench for the command register block
module telemetry_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CH = 2;
    logic CLK = 0, RST_N = 0, wr = 0, rd = 0, c0 = 0, c1 = 1, uns, rv;
    logic [7:0] code = 8'h00;
    logic [15:0] wd = 16'h0000, tv = 16'h0000, rdat;
    logic [CH+1:0] trig = '0;
    logic [CH-1:0] l11 = 2'b10, warn = '0, tgt = '0;
    logic [CH-1:0] ctl, fse, hre, srq, dnow, dsoft, isl;
    telemetry_pkg::sample_t [CH+1:0] smp;
    telemetry_pkg::chan_cfg_t [CH-1:0] cfg;
    int error_cnt = 0, cmp_count = 0;
    always #4 CLK = ~CLK;
    telemetry_engine_model #(.N(CH+2)) eng (.CLK(CLK), .trig(trig),
        .value(tv), .smp(smp));
    telemetry_regs #(.CHANNELS(CH)) dut (.CLK(CLK), .RST_N(RST_N),
        .CMD_WR(wr), .CMD_RD(rd), .CMD_CODE(code), .CMD_WDATA(wd),
        .CMD_RDATA(rdat), .CMD_RVALID(rv), .CMD_UNSUPPORTED(uns),
        .VIN_SAMPLE(smp[0]), .TEMP_SAMPLE(smp[1]), .VOUT_SAMPLE(smp[CH+1:2]),
        .VOUT_L11_IN(l11), .CONTROL_INPUT_ZERO(c0), .CONTROL_INPUT_ONE(c1),
        .WARN_HIT(warn), .TARGET_REACHED(tgt), .CHAN_CFG(cfg),
        .CHAN_CONTROL(ctl), .FAST_SERVO_EN(fse), .ADC_HIRES_EN(hre),
        .SERVO_REQ(srq), .DAC_CONNECT_NOW(dnow), .DAC_SOFT_CONNECT(dsoft),
        .VOUT_IS_L11(isl));
    // ****
    // tasks
    // ****
    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk1(input logic g, input logic e);
        chk16({15'h0000, g}, {15'h0000, e});
    endtask
    task automatic wr_cmd(input logic [7:0] c, input logic [15:0] d);
        @(posedge CLK);
        wr <= 1'b1;
        code <= c;
        wd <= d;
        @(posedge CLK);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_cmd(input logic [7:0] c, input logic [15:0] e);
        @(posedge CLK);
        rd <= 1'b1;
        code <= c;
        @(posedge CLK);
        rd <= 1'b0;
        #1;
        // bounded wait: a lost answer must not hang the run
        for (int n = 0; n < 4 && rv !== 1'b1; n++)
            @(posedge CLK) #1;
        if (rv !== 1'b1)
        begin
            error_cnt++;
            print_verdict();
        end
        chk16(rdat, e);
    endtask
    task automatic push(input int i, input logic [15:0] v);
        @(posedge CLK);
        trig[i] <= 1'b1;
        tv <= v;
        @(posedge CLK);
        trig[i] <= 1'b0;
    endtask
    // ****
    // sequence
    // ****
    initial
    begin
        repeat (5) @(posedge CLK);
        RST_N <= 1'b1;
        rd_cmd(8'h98, 16'h0011);
        rd_cmd(8'h77, 16'h0000);
        chk1(uns, 1'b1);
        wr_cmd(8'h98, 16'h00ff);
        chk1(uns, 1'b1);
        rd_cmd(8'h98, 16'h0011);
        wr_cmd(8'hd0, 16'hffff);
        rd_cmd(8'hd0, 16'h0fff);
        chk1(fse[0], 1'b0);
        chk1(cfg[0].sup_8mv, 1'b1);
        chk1(ctl[0], 1'b1);
        wr_cmd(8'h00, 16'h0001);
        wr_cmd(8'hd0, 16'h0a5a);
        chk1(hre[1], 1'b1);
        chk1(ctl[1], 1'b0);
        rd_cmd(8'hd0, 16'h0a5a);
        wr_cmd(8'h00, 16'h0000);
        rd_cmd(8'hd0, 16'h0fff);
        chk1(hre[0], 1'b0);
        for (int m = 0; m < 4; m++)
        begin
            wr_cmd(8'hd0, 16'(m << 4));
            chk1(dnow[0], m == 2);
            chk1(dsoft[0], m == 0 || m == 3);
            chk1(srq[0], m == 0);
        end
        @(posedge CLK) tgt <= '1;
        wr_cmd(8'hd0, 16'h0040);
        chk1(srq[0], 1'b0);
        @(posedge CLK) warn <= '1;
        #1 chk1(srq[0], 1'b1);
        @(posedge CLK) warn <= '0;
        wr_cmd(8'hd0, 16'h0080);
        chk1(srq[0], 1'b1);
        wr_cmd(8'hd0, 16'h0090);
        chk1(srq[0], 1'b0);
        push(0, 16'h1234);
        rd_cmd(8'h88, 16'h1234);
        push(1, 16'h0f1e);
        rd_cmd(8'h8d, 16'h0f1e);
        push(3, 16'hbeef);
        push(2, 16'h5a5a);
        wr_cmd(8'h00, 16'h0001);
        rd_cmd(8'h8b, 16'hbeef);
        chk1(isl[1], 1'b1);
        wr_cmd(8'h00, 16'h0000);
        rd_cmd(8'h8b, 16'h5a5a);
        chk1(isl[0], 1'b0);
        print_verdict();
    end
endmodule
